// *** inc/sepr_link_if.sv ***
/*
  Two-wire link between the master end and the EEPROM end.
  Assumes open-drain data: a party pulls the line low while its enable
  is high, and the line reads high when nobody pulls.
*/
`default_nettype none

interface sepr_link_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of both open-drain drivers with the pull-up.
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (output scl, output host_sda_oe, input sda);
  modport dev (input scl, output dev_sda_oe, input sda);
endinterface : sepr_link_if

`default_nettype wire

// *** inc/sepr_pkg.sv ***
/*
  Shared constants for the serial EEPROM read path: device type codes,
  address layout, reset values, link timing and host command kinds.
  Assumes a single 10 MHz system clock on both ends of the link.
*/
`default_nettype none

package sepr_pkg;
  // Device type nibbles carried in the top of the device address word.
  localparam logic [3:0] SEPR_TYPE_MEM = 4'hA;
  localparam logic [3:0] SEPR_TYPE_ID = 4'hB;
  // Identification page: 128 bytes selected by the low seven bits.
  localparam int SEPR_ID_OFS_W = 7;
  localparam int SEPR_ID_BYTES = 128;
  // Address bit that marks a lock command instead of a page access.
  localparam int SEPR_LOCK_SEL_POS = 10;
  localparam logic [15:0] SEPR_ADDR_RST = 16'h0000;
  // Bit slots of one byte on the link; slot 8 is the acknowledge.
  localparam logic [3:0] SEPR_ACK_SLOT = 4'h8;
  localparam logic [3:0] SEPR_END_SLOT = 4'h9;
  // Clock rate and link clock period; the host divides by quarters.
  localparam int SEPR_CLK_PERIOD_NS = 100;
  localparam int SEPR_SCL_PERIOD_NS = 10000;
  localparam int SEPR_SCL_QTR_CYC =
    SEPR_SCL_PERIOD_NS / (4 * SEPR_CLK_PERIOD_NS);
  // Kinds of transfer the host end can run.
  typedef enum logic [1:0] {
    SEPR_CMD_CUR = 2'b00,
    SEPR_CMD_RAND = 2'b01,
    SEPR_CMD_LOCKQ = 2'b10
  } sepr_cmd_t;
endpackage : sepr_pkg

`default_nettype wire

// *** src/sepr_dev.sv ***
/*
  EEPROM end of the two-wire link: device addressing, dummy address
  write, current, random and sequential reads of the main array and of
  the identification page, and the lock status answer.
  Assumes the link clock and the select pins are asynchronous inputs and
  that the array is filled through the load port before it is read.
*/
`default_nettype none

module sepr_dev
  import sepr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  sepr_link_if.dev link,
  input wire logic chip_select_pin_high_i,
  input wire logic chip_select_pin_mid_i,
  input wire logic chip_select_pin_low_i,
  input wire logic id_page_locked_i,
  input wire logic load_en_i,
  input wire logic load_id_i,
  input wire logic [15:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  output logic standby_o,
  output logic [15:0] addr_cnt_o
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks and types.

  // The array must hold at least two identification pages worth of bytes.
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_chk_addr_w
    $error("sepr_dev: ADDR_W must lie between 8 and 16");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b010,
    ST_ALO = 3'b011,
    ST_WDAT = 3'b100,
    ST_READ = 3'b101
  } sepr_dst_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [2:0] cs_m;
    logic [2:0] cs_s;
    sepr_dst_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ahi;
    logic [15:0] addr;
    logic id_sel;
    logic oe;
    logic stby;
  } sepr_dstate_t;

  // Bus lines idle high, so the samplers start high to avoid a false
  // start condition right after reset.
  localparam sepr_dstate_t DEV_RST = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    cs_m: 3'h0, cs_s: 3'h0, st: ST_IDLE,
    bcnt: 4'h0, sh: 8'h00, tx: 8'h00, ahi: 8'h00,
    addr: SEPR_ADDR_RST, id_sel: 1'b0, oe: 1'b0, stby: 1'b1
  };

  sepr_dstate_t r;
  sepr_dstate_t n;

  ////////////////////////////////////////////////////////////////////////
  // Storage: main array and identification page.

  logic [7:0] mem [2**ADDR_W];
  logic [7:0] idp [SEPR_ID_BYTES];
  logic [7:0] rd_byte;

  // Contents are preloaded from the user side; the link never writes
  // them, so the lock only shows in the acknowledge of a data byte sent to the identification page.
  always_ff @(posedge sys_clk_i) begin
    if (load_en_i) begin
      if (load_id_i) begin
        idp[load_addr_i[SEPR_ID_OFS_W-1:0]] <= load_data_i;
      end else begin
        mem[load_addr_i[ADDR_W-1:0]] <= load_data_i;
      end
    end
  end

  // The page offset ignores the upper counter bits.
  assign rd_byte = r.id_sel ? idp[r.addr[SEPR_ID_OFS_W-1:0]]
                            : mem[r.addr[ADDR_W-1:0]];

  ////////////////////////////////////////////////////////////////////////
  // Link events, seen on the synchronised copies only.

  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic type_ok;
  logic addr_hit;
  logic ack_ok;

  assign rise = r.scl_s & ~r.scl_d;
  assign fall = ~r.scl_s & r.scl_d;
  // Data moving while the clock stays high frames a transfer.
  assign start_c = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign stop_c = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
  assign type_ok = (r.sh[7:4] == SEPR_TYPE_MEM) ||
                   (r.sh[7:4] == SEPR_TYPE_ID);
  assign addr_hit = type_ok && (r.sh[3:1] == r.cs_s);

  // Acknowledge decision for the byte just received.
  always_comb begin
    unique case (r.st)
      ST_DEV: ack_ok = addr_hit;
      ST_WDAT: ack_ok = ~(r.id_sel & id_page_locked_i);
      default: ack_ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    n = r;
    n.scl_m = link.scl;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = link.sda;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    n.cs_m = {chip_select_pin_high_i, chip_select_pin_mid_i,
              chip_select_pin_low_i};
    n.cs_s = r.cs_m;
    if (stop_c) begin
      n.st = ST_IDLE;
      n.oe = 1'b0;
      n.bcnt = 4'h0;
    end else if (start_c) begin
      // A repeated start is accepted in any state.
      n.st = ST_DEV;
      n.oe = 1'b0;
      n.bcnt = 4'h0;
    end else if (r.st == ST_READ) begin
      if (rise && r.bcnt < SEPR_END_SLOT) begin
        n.bcnt = r.bcnt + 4'h1;
      end
      if (rise && r.bcnt == SEPR_ACK_SLOT) begin
        n.sh[0] = r.sda_s; // Master acknowledge, low means more.
      end
      if (fall) begin
        if (r.bcnt != 4'h0 && r.bcnt < SEPR_ACK_SLOT) begin
          n.tx = {r.tx[6:0], 1'b0};
          n.oe = ~r.tx[6];
        end else if (r.bcnt == SEPR_ACK_SLOT) begin
          n.oe = 1'b0;
          // Natural wrap of the counter covers the whole array.
          n.addr = r.addr + 16'h0001;
        end else if (r.bcnt == SEPR_END_SLOT) begin
          n.bcnt = 4'h0;
          if (!r.sh[0]) begin
            n.tx = rd_byte;
            n.oe = ~rd_byte[7];
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
    end else if (r.st != ST_IDLE) begin
      if (rise && r.bcnt < SEPR_ACK_SLOT) begin
        n.sh = {r.sh[6:0], r.sda_s};
        n.bcnt = r.bcnt + 4'h1;
      end
      if (fall && r.bcnt == SEPR_ACK_SLOT) begin
        n.bcnt = SEPR_END_SLOT;
        n.oe = ack_ok;
        if (r.st == ST_DEV) begin
          n.id_sel = (r.sh[7:4] == SEPR_TYPE_ID);
          if (!addr_hit) begin
            n.st = ST_IDLE;
          end
        end
      end
      if (fall && r.bcnt == SEPR_END_SLOT) begin
        n.bcnt = 4'h0;
        n.oe = 1'b0;
        unique case (r.st)
          ST_DEV: begin
            if (r.sh[0]) begin
              n.st = ST_READ;
              n.tx = rd_byte;
              n.oe = ~rd_byte[7];
            end else begin
              n.st = ST_AHI;
            end
          end
          ST_AHI: begin
            n.ahi = r.sh;
            n.st = ST_ALO;
          end
          ST_ALO: begin
            n.addr = {r.ahi, r.sh};
            n.st = ST_WDAT;
          end
          default: begin
            // Data after the address is not stored, but an accepted
            // byte still moves the counter as a write would.
            if (ack_ok) begin
              n.addr = r.addr + 16'h0001;
            end
          end
        endcase
      end
    end
    n.stby = (n.st == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  // The counter keeps its value across transfers until reset.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  assign link.dev_sda_oe = r.oe;
  assign standby_o = r.stby;
  assign addr_cnt_o = r.addr;

endmodule : sepr_dev

`default_nettype wire

// *** src/sepr_host.sv ***
/*
  Master end of the two-wire link: runs current, random and sequential
  reads and the lock status query on request, making the link clock
  from the system clock by a quarter-period divider.
  Assumes one command at a time and a pulled-up open-drain data line.
*/
`default_nettype none

module sepr_host
  import sepr_pkg::*;
#(
  parameter int QTR_CYC = SEPR_SCL_QTR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  sepr_link_if.host link,
  input wire logic cmd_valid_i,
  input wire sepr_cmd_t cmd_kind_i,
  input wire logic cmd_id_i,
  input wire logic [2:0] cmd_cs_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  output logic cmd_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic nack_o
);

  ////////////////////////////////////////////////////////////////////////
  // Checks and types.

  // The device needs a few cycles to see each clock edge.
  if (QTR_CYC < 8 || QTR_CYC > 255) begin : g_chk_qtr
    $error("sepr_host: QTR_CYC must lie between 8 and 255");
  end

  typedef enum logic [3:0] {
    H_IDLE = 4'b0000,
    H_START1 = 4'b0001,
    H_DEVW = 4'b0010,
    H_AHI = 4'b0011,
    H_ALO = 4'b0100,
    H_LDAT = 4'b0101,
    H_START2 = 4'b0110,
    H_DEVR = 4'b0111,
    H_RDAT = 4'b1000,
    H_STOP = 4'b1001
  } sepr_hseq_t;

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    sepr_hseq_t seq;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] q;
    logic [7:0] sh;
    logic [7:0] left;
    sepr_cmd_t kind;
    logic [2:0] cs;
    logic id;
    logic [15:0] addr;
    logic scl;
    logic oe;
    logic ready;
    logic [7:0] rdat;
    logic rvalid;
    logic done;
    logic nack;
  } sepr_hstate_t;

  localparam sepr_hstate_t HOST_RST = '{
    sda_m: 1'b1, sda_s: 1'b1, seq: H_IDLE, ph: 2'h0, bitn: 4'h0,
    q: 8'h00, sh: 8'h00, left: 8'h00, kind: SEPR_CMD_CUR, cs: 3'h0,
    id: 1'b0, addr: SEPR_ADDR_RST, scl: 1'b1, oe: 1'b0, ready: 1'b1,
    rdat: 8'h00, rvalid: 1'b0, done: 1'b0, nack: 1'b0
  };

  sepr_hstate_t r;
  sepr_hstate_t n;

  // Byte the master sends in a given step of the sequence.
  function automatic logic [7:0] tx_byte(input sepr_hstate_t s);
    logic [3:0] typ;
    typ = s.id ? SEPR_TYPE_ID : SEPR_TYPE_MEM;
    unique case (s.seq)
      H_DEVW: tx_byte = {typ, s.cs, 1'b0};
      H_AHI: tx_byte = s.addr[15:8];
      H_ALO: tx_byte = s.addr[7:0];
      H_DEVR: tx_byte = {typ, s.cs, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  endfunction : tx_byte

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: each bit and each frame edge takes four quarters.

  logic tick;
  logic is_tx;
  logic [7:0] txb;

  assign tick = (r.q == 8'(QTR_CYC - 1));
  assign is_tx = (r.seq == H_DEVW) || (r.seq == H_AHI) ||
                 (r.seq == H_ALO) || (r.seq == H_LDAT) ||
                 (r.seq == H_DEVR);
  assign txb = tx_byte(r);

  always_comb begin
    n = r;
    n.sda_m = link.sda;
    n.sda_s = r.sda_m;
    n.rvalid = 1'b0;
    n.done = 1'b0;
    n.q = tick ? 8'h00 : r.q + 8'h01;
    if (r.seq == H_IDLE) begin
      n.ph = 2'h0;
      n.ready = 1'b1;
      if (cmd_valid_i && r.ready) begin
        n.ready = 1'b0;
        n.kind = cmd_kind_i;
        n.id = cmd_id_i;
        n.cs = cmd_cs_i;
        n.addr = cmd_addr_i;
        n.left = cmd_len_i;
        n.nack = 1'b0;
        n.bitn = 4'h0;
        n.seq = (cmd_kind_i == SEPR_CMD_CUR) ? H_START2 : H_START1;
      end
    end else if (tick) begin
      n.ph = r.ph + 2'h1;
      if (r.seq == H_START1 || r.seq == H_START2) begin
        unique case (r.ph)
          2'h0: begin
            n.scl = 1'b0;
            n.oe = 1'b0;
          end
          2'h1: n.scl = 1'b1;
          2'h2: n.oe = 1'b1;
          2'h3: begin
            n.scl = 1'b0;
            n.seq = (r.seq == H_START1) ? H_DEVW : H_DEVR;
          end
        endcase
      end else if (r.seq == H_STOP) begin
        unique case (r.ph)
          2'h0: begin
            n.scl = 1'b0;
            n.oe = 1'b1;
          end
          2'h1: n.scl = 1'b1;
          2'h2: n.oe = 1'b0;
          2'h3: begin
            n.seq = H_IDLE;
            n.done = 1'b1;
          end
        endcase
      end else begin
        unique case (r.ph)
          2'h0: begin
            n.scl = 1'b0;
            if (r.bitn < SEPR_ACK_SLOT) begin
              n.oe = is_tx & ~txb[3'(4'h7 - r.bitn)];
            end else begin
              // Acknowledge only while more bytes are wanted.
              n.oe = ~is_tx & (r.left > 8'h01);
            end
          end
          2'h1: n.scl = 1'b0;
          2'h2: n.scl = 1'b1;
          2'h3: begin
            n.bitn = r.bitn + 4'h1;
            if (r.bitn < SEPR_ACK_SLOT) begin
              n.sh = {r.sh[6:0], r.sda_s};
            end else begin
              n.bitn = 4'h0;
              if (!is_tx) begin
                n.rdat = r.sh;
                n.rvalid = 1'b1;
                n.left = r.left - 8'h01;
                if (r.left <= 8'h01) begin
                  n.seq = H_STOP;
                end
              end else if (r.seq == H_LDAT) begin
                n.nack = r.sda_s;
                n.seq = H_STOP;
              end else if (r.sda_s) begin
                n.nack = 1'b1;
                n.seq = H_STOP;
              end else begin
                unique case (r.seq)
                  H_DEVW: n.seq = H_AHI;
                  H_AHI: n.seq = H_ALO;
                  H_ALO: n.seq = (r.kind == SEPR_CMD_LOCKQ) ? H_LDAT
                                                           : H_START2;
                  default: n.seq = H_RDAT;
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  assign link.scl = r.scl;
  assign link.host_sda_oe = r.oe;
  assign cmd_ready_o = r.ready;
  assign rd_data_o = r.rdat;
  assign rd_valid_o = r.rvalid;
  assign done_o = r.done;
  assign nack_o = r.nack;

endmodule : sepr_host

`default_nettype wire

// *** testbench/sepr_monitor.sv ***
/*
  Checker for the two-wire link between the host end and the device end.
  Assumes it sees the interface signals in the system clock domain.
*/
`default_nettype none

module sepr_monitor
  import sepr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_r, sda_r, rd_r;
  logic [3:0] bit_r, byte_r, lo_r;
  logic [7:0] sh_r;
  logic rise, stop;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////
  // Link edges; both lines are clean here, so no filter is needed.
  assign rise = scl & ~scl_r;
  assign stop = scl & scl_r & ~sda_r & sda;

  // Slot and byte position in a frame; a start restarts the count.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      rd_r <= 1'b0;
      bit_r <= 4'h0;
      byte_r <= 4'h0;
      lo_r <= 4'h0;
      sh_r <= 8'h00;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      lo_r <= scl ? 4'h0 : ((lo_r == 4'hF) ? lo_r : lo_r + 4'h1);
      if (scl && scl_r && sda_r && !sda) begin
        bit_r <= 4'h0;
        byte_r <= 4'h0;
      end else if (rise) begin
        sh_r <= {sh_r[6:0], sda};
        bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
        if (bit_r == 4'h8 && byte_r != 4'hF) byte_r <= byte_r + 4'h1;
        if (bit_r == 4'h7 && byte_r == 4'h0) rd_r <= sda;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_ADDR_TYPE: assert property (
    rise && bit_r == 4'h4 && byte_r == 4'h0
    |-> sh_r[3:0] == SEPR_TYPE_MEM || sh_r[3:0] == SEPR_TYPE_ID)
    else $error("device address word has an unknown type nibble");
  AST_WORD_ADDR_ACK: assert property (
    rise && !rd_r && (byte_r == 4'h1 || byte_r == 4'h2) && bit_r == 4'h8
    |-> !sda)
    else $error("word address byte was not acknowledged");
  AST_MASTER_LISTENS: assert property (
    rise && rd_r && byte_r != 4'h0 && bit_r != 4'h0 && bit_r < 4'h8
    |-> !host_sda_oe)
    else $error("host pulls data while the device sends a byte");
  AST_ACK_SLOT_FREE: assert property (
    rise && rd_r && byte_r != 4'h0 && bit_r == 4'h8 |-> !dev_sda_oe)
    else $error("device drives data in the master acknowledge slot");
  AST_DEV_LAG: assert property (
    $changed(dev_sda_oe) |-> lo_r >= 4'h1 && lo_r <= 4'h8)
    else $error("device data changed outside the low clock phase");
  AST_STOP_RELEASED: assert property (
    stop |-> !dev_sda_oe [*8])
    else $error("device still drives data around a stop");
  AST_IDLE_SCL: assert property (
    stop |-> scl [*8])
    else $error("link clock moved right after a stop");
  AST_SCL_HIGH: assert property (
    $rose(scl) |-> scl [*8])
    else $error("link clock high phase too short");

  // Main scenarios: sequential acknowledge, locked page answer, stop.
  cover property (rise && rd_r && byte_r == 4'h2 && bit_r == 4'h8 && !sda);
  cover property (rise && !rd_r && byte_r == 4'h3 && bit_r == 4'h8 && sda);
  cover property (stop);
endmodule : sepr_monitor

`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Bench top: host and device ends joined by the link interface.
  Assumes one command at a time and a shortened link clock divider.
*/
`default_nettype none

module tb_top
  import sepr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0, cmd_id = 1'b0, locked = 1'b0;
  sepr_cmd_t cmd_kind = SEPR_CMD_CUR;
  logic [2:0] cmd_cs = 3'h0, pins = 3'h0;
  logic [15:0] cmd_addr = 16'h0000, ld_addr = 16'h0000, cnt = 16'h0000;
  logic [7:0] cmd_len = 8'h01, ld_data = 8'h00;
  logic ld_en = 1'b0, ld_id = 1'b0;
  logic cmd_ready, rd_valid, done, nack, standby;
  logic [7:0] rd_data;
  logic [15:0] addr_cnt;
  logic [7:0] exp_q[$];
  logic [7:0] mem[int];
  logic [7:0] idm[128];
  logic [31:0] seed = 32'h0000_8FC8;
  int n_errors = 0, total_checks = 0, i;
  logic scl_q = 1'b1, sda_q = 1'b1;
  logic [3:0] bit_n = 4'h0;
  logic [7:0] sh = 8'h00, adr_seen = 8'h00;

  sepr_link_if link ();
  sepr_host #(.QTR_CYC(8)) sepr_host_inst (.sys_clk_i(sys_clk),
    .resetn_i(resetn), .link(link), .cmd_valid_i(cmd_valid),
    .cmd_kind_i(cmd_kind), .cmd_id_i(cmd_id), .cmd_cs_i(cmd_cs),
    .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .cmd_ready_o(cmd_ready),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done),
    .nack_o(nack));
  sepr_dev sepr_dev_inst (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .link(link), .chip_select_pin_high_i(pins[2]),
    .chip_select_pin_mid_i(pins[1]), .chip_select_pin_low_i(pins[0]),
    .id_page_locked_i(locked), .load_en_i(ld_en), .load_id_i(ld_id),
    .load_addr_i(ld_addr), .load_data_i(ld_data), .standby_o(standby),
    .addr_cnt_o(addr_cnt));
  sepr_monitor sepr_monitor_inst (.sys_clk_i(sys_clk), .resetn_i(resetn),
    .scl(link.scl), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  //////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  always #50 sys_clk = ~sys_clk;

  // Keeps the last device address word sent after any start.
  always @(posedge sys_clk) begin
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (link.scl && scl_q && sda_q && !link.sda) begin
      bit_n <= 4'h0;
    end else if (link.scl && !scl_q) begin
      sh <= {sh[6:0], link.sda};
      if (bit_n != 4'hF) bit_n <= bit_n + 4'h1;
      if (bit_n == 4'h7) adr_seen <= {sh[6:0], link.sda};
    end
  end

  // Each read byte is matched against the oldest queued prediction.
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      check("busy standby", standby, 16'h0000);
      if (exp_q.size() == 0) begin
        check("extra byte", 16'h0001, 16'h0000);
      end else begin
        check("rd_data", rd_data, exp_q.pop_front());
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Writes one random byte into the array or the identification page.
  task automatic load(input logic id, input logic [15:0] a);
    seed = xs(seed);
    @(posedge sys_clk);
    ld_en <= 1'b1;
    ld_id <= id;
    ld_addr <= a;
    ld_data <= seed[7:0];
    if (id) idm[a[6:0]] = seed[7:0];
    else mem[int'(a)] = seed[7:0];
    @(posedge sys_clk);
    ld_en <= 1'b0;
  endtask : load

  // Runs one command; the counter model predicts the bytes it returns.
  task automatic rd(input sepr_cmd_t k, input logic id,
    input logic [2:0] cs, input logic [15:0] a, input logic [7:0] n,
    input logic nk);
    int j;
    logic [3:0] ty;
    ty = id ? SEPR_TYPE_ID : SEPR_TYPE_MEM;
    // A lock query loads its address too; an accepted byte moves it.
    if ((k == SEPR_CMD_RAND && !nk) || k == SEPR_CMD_LOCKQ) cnt = a;
    for (j = 0; j < n && k != SEPR_CMD_LOCKQ && !nk; j++) begin
      exp_q.push_back(id ? idm[cnt[6:0]] : mem[int'(cnt)]);
      cnt = cnt + 16'h0001;
    end
    if (k == SEPR_CMD_LOCKQ && !nk) cnt = cnt + 16'h0001;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_id <= id;
    cmd_cs <= cs;
    cmd_addr <= a;
    cmd_len <= n;
    // The request stands until the rising edge after the host is seen ready at a falling edge.
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (j = 0; j < 20000 && done !== 1'b1; j++) @(negedge sys_clk);
    check("done", done, 16'h0001);
    check("busy", cmd_ready, 16'h0000);
    check("nack", nack, nk);
    check("standby", standby, 16'h0001);
    check("bytes left", 16'(exp_q.size()), 16'h0000);
    check("dev addr", adr_seen, {ty, cs, 1'(k != SEPR_CMD_LOCKQ)});
    check("addr_cnt", addr_cnt, cnt);
    @(negedge sys_clk);
    check("ready", cmd_ready, 16'h0001);
  endtask : rd

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reads of every kind, wrap, page, lock and bad select.
  initial begin
    seed = xs(seed);
    pins <= seed[2:0];
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    check("reset standby", standby, 16'h0001);
    check("reset counter", addr_cnt, SEPR_ADDR_RST);
    for (i = 0; i < 5; i++) load(1'b0, 16'h1234 + 16'(i));
    for (i = -2; i < 1; i++) load(1'b0, 16'(i));
    for (i = 125; i < 128; i++) load(1'b1, 16'(i));
    rd(SEPR_CMD_RAND, 1'b0, pins, 16'h1234, 8'h03, 1'b0);
    rd(SEPR_CMD_CUR, 1'b0, pins, 16'h0000, 8'h02, 1'b0);
    rd(SEPR_CMD_RAND, 1'b0, pins, 16'hFFFE, 8'h03, 1'b0);
    rd(SEPR_CMD_RAND, 1'b1, pins, 16'h8B7D, 8'h03, 1'b0);
    rd(SEPR_CMD_CUR, 1'b0, ~pins, 16'h0000, 8'h01, 1'b1);
    rd(SEPR_CMD_LOCKQ, 1'b1, pins, 16'h0000, 8'h01, 1'b0);
    @(posedge sys_clk);
    locked <= 1'b1;
    rd(SEPR_CMD_LOCKQ, 1'b1, pins, 16'h0000, 8'h01, 1'b1);
    test_done();
  end

  // Watchdog: the sequence needs well under 20000 cycles.
  initial begin
    #5000000;
    check("watchdog", 16'h0001, 16'h0000);
    test_done();
  end
endmodule : tb_top

`default_nettype wire
